// >>> dse_pkg.sv
// Purpose: shared types and constants for the ddr storage element pair
// Assumes: one core clock at 40 MHz; link clocks arrive as pins
// Notes: control polarity bits are xor masks, zero means active high
package dse_pkg;
   localparam int CORE_PERIOD_NS = 25;
   localparam int OUT_HALF_PERIOD_NS = 100;
   // longest time, rounded down, never below one cycle
   localparam int OUT_HALF_CYCLES = (OUT_HALF_PERIOD_NS / CORE_PERIOD_NS) < 1 ? 1 :
      (OUT_HALF_PERIOD_NS / CORE_PERIOD_NS);
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_WIDTH = 4;
   localparam logic RESET_Q = 1'b0;
   localparam logic [4:0] POL_DEFAULT = 5'h00;

   // per-element control inputs, before polarity
   typedef struct packed {
      logic ce;
      logic gate;
      logic ge;
      logic sr;
      logic reverse_set_reset;
   } dse_ctl_type;

   // per-element configuration
   typedef struct packed {
      logic latch_mode;
      logic sr_async;
      logic sr_is_set;
      logic [4:0] pol;
   } dse_cfg_type;

   // one output word: two data bits and two enable bits
   typedef struct packed {
      logic oe_rise;
      logic oe_fall;
      logic d_rise;
      logic d_fall;
   } dse_tx_word_type;

   typedef enum logic [2:0] {
      PH_IDLE = 3'h1,
      PH_HIGH = 3'h2,
      PH_LOW  = 3'h4
   } dse_phase_type;
endpackage

// >>> dse_storage_el.sv
// Purpose: one storage element, flip-flop or transparent latch
// Assumes: clk_evt is a one-cycle pulse marking the element clock rising edge
// Notes: async clear acts on q at once; latch is modelled in core_clk time
`timescale 1ns/10ps
module dse_storage_el
   import dse_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire dse_cfg_type cfg,
   input wire dse_ctl_type ctl,
   input wire logic clk_evt,
   input wire logic d,
   output logic q
);
   dse_ctl_type act;
   logic r, s, clr, pre, open;
   logic stored_q, stored_d;

   assign act = dse_ctl_type'(ctl ^ cfg.pol);
   // sr drives the chosen function, rev the opposite one, same style
   assign r = ~cfg.sr_async & ((act.sr & ~cfg.sr_is_set) | (act.reverse_set_reset & cfg.sr_is_set));
   assign s = ~cfg.sr_async & ((act.sr & cfg.sr_is_set) | (act.reverse_set_reset & ~cfg.sr_is_set));
   assign clr = cfg.sr_async & ((act.sr & ~cfg.sr_is_set) | (act.reverse_set_reset & cfg.sr_is_set));
   assign pre = cfg.sr_async & ((act.sr & cfg.sr_is_set) | (act.reverse_set_reset & ~cfg.sr_is_set));
   assign open = act.gate & act.ge;

   always_comb begin
      stored_d = stored_q;
      if (clr) begin
         stored_d = 1'b0;
      end else if (pre && (cfg.latch_mode || clk_evt)) begin
         stored_d = 1'b1;
      end else if (cfg.latch_mode) begin
         if (r) begin
            stored_d = 1'b0;
         end else if (s) begin
            stored_d = 1'b1;
         end else if (open) begin
            stored_d = d;
         end
      end else if (clk_evt) begin
         if (r) begin
            stored_d = 1'b0;
         end else if (s) begin
            stored_d = 1'b1;
         end else if (act.ce) begin
            stored_d = d;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stored_q <= RESET_Q;
      end else begin
         stored_q <= stored_d;
      end
   end

   // latch answers at once, flip-flop only after its edge
   always_comb begin
      if (clr) begin
         q = 1'b0;
      end else if (!cfg.latch_mode) begin
         q = stored_q;
      end else if (pre || (s && !r)) begin
         q = 1'b1;
      end else if (r) begin
         q = 1'b0;
      end else if (open) begin
         q = d;
      end else begin
         q = stored_q;
      end
   end
endmodule // dse_storage_el

// >>> dse_fifo.sv
// Purpose: small flip-flop fifo with valid and ready on both sides
// Assumes: single clock
// Notes: no bypass; a word written is readable one cycle later
`timescale 1ns/10ps
module dse_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_comb begin
      wr_d = push ? ptr_inc(wr_q) : wr_q;
      rd_d = pop ? ptr_inc(rd_q) : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = (AW+1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
         cnt_d = (AW+1)'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage needs no reset; empty count guards reads
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule // dse_fifo

// >>> dse_io_top.sv
// Purpose: ddr output, output-enable and input register pairs plus one slice pair
// Assumes: link clocks and pad data are sampled by core_clk through two flip-flops
// Notes: output ddr clock is made here by a divider, so it is no second domain
`timescale 1ns/10ps
module dse_io_top
   import dse_pkg::*;
#(
   parameter int HALF_CYCLES = OUT_HALF_CYCLES,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rstn,
   // configuration
   input wire dse_cfg_type elem_cfg,
   input wire logic single_clock,
   input wire logic diff_standard,
   input wire logic cascade_en,
   input wire logic clock_mirror,
   input wire logic out_enable,
   input wire logic in_ce,
   input wire logic io_sr,
   input wire logic io_rev,
   // transmit stream
   input wire dse_tx_word_type tx_word,
   input wire logic tx_valid,
   output logic tx_ready,
   // pads
   output logic pad_out_q,
   output logic pad_oe_q,
   output logic fwd_clk_q,
   input wire logic pad_in,
   input wire logic input_clock_a,
   input wire logic input_clock_b,
   input wire logic cascade_in,
   output logic cascade_out_q,
   // receive pair
   output logic captured_bit_first,
   output logic captured_bit_second,
   output logic rx_valid_q,
   // logic slice
   input wire dse_ctl_type slice_ctl,
   input wire logic upper_comb,
   input wire logic upper_bypass_in,
   input wire logic upper_sel_bypass,
   input wire logic lower_comb,
   input wire logic lower_bypass_in,
   input wire logic lower_sel_bypass,
   output logic upper_q,
   output logic lower_q
);
   // pin synchronisers: clock a, clock b, data, cascade
   logic [SYNC_WIDTH-1:0] meta_q, sync_q, prev_q;
   // edges count only once prev_q holds a real pin value, else a high pin fakes one
   logic [2:0] warm_q;
   logic a_rise, b_edge, in_data;
   logic b_edge_q;

   // output clock generator
   dse_phase_type ph_q, ph_d;
   logic [7:0] cnt_q, cnt_d;
   logic rise_evt, fall_evt;

   // transmit path
   dse_tx_word_type fifo_word, cur_q, cur_d;
   logic fifo_valid, fifo_pop;
   logic rise_data, fall_data, tx_ce;
   logic out_rise, out_fall, oe_rise, oe_fall;
   dse_ctl_type tx_ctl, in_ctl;

   // receive path
   logic in_rise, in_fall;
   logic first_d, second_d, rx_valid_d, casc_d;

   // slice
   logic upper_d, lower_d, upper_el, lower_el;

   // output mux
   logic pad_out_d, pad_oe_d, fwd_clk_d;

   function automatic logic ddr_mux(input dse_phase_type ph, input logic hi, input logic lo);
      ddr_mux = (ph == PH_HIGH) ? hi : ((ph == PH_LOW) ? lo : 1'b0);
   endfunction

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
         warm_q <= 3'h0;
      end else begin
         warm_q <= {warm_q[1:0], 1'b1};
         meta_q <= {cascade_in, pad_in, input_clock_b, input_clock_a};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign a_rise = warm_q[2] & sync_q[0] & ~prev_q[0];
   // one clock on both edges, or a second clock of its own
   assign b_edge = warm_q[2] &
      (single_clock ? (~sync_q[0] & prev_q[0]) : (sync_q[1] & ~prev_q[1]));
   // cascade only for a differential standard; partner route never reaches fabric
   assign in_data = (cascade_en & diff_standard) ? sync_q[3] : sync_q[2];

   // phase generator: rise and fall events of the forwarded ddr clock
   always_comb begin
      ph_d = ph_q;
      cnt_d = cnt_q;
      rise_evt = 1'b0;
      fall_evt = 1'b0;
      case (ph_q)
         PH_IDLE: begin
            if (out_enable) begin
               ph_d = PH_HIGH;
               cnt_d = 8'(HALF_CYCLES - 1);
               rise_evt = 1'b1;
            end
         end
         PH_HIGH: begin
            if (cnt_q != 8'h00) begin
               cnt_d = 8'(cnt_q - 1'b1);
            end else begin
               ph_d = PH_LOW;
               cnt_d = 8'(HALF_CYCLES - 1);
               fall_evt = 1'b1;
            end
         end
         PH_LOW: begin
            if (cnt_q != 8'h00) begin
               cnt_d = 8'(cnt_q - 1'b1);
            end else if (out_enable) begin
               ph_d = PH_HIGH;
               cnt_d = 8'(HALF_CYCLES - 1);
               rise_evt = 1'b1;
            end else begin
               ph_d = PH_IDLE;
            end
         end
         default: begin
            ph_d = PH_IDLE;
            cnt_d = 8'h00;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ph_q <= PH_IDLE;
         cnt_q <= 8'h00;
      end else begin
         ph_q <= ph_d;
         cnt_q <= cnt_d;
      end
   end

   // fifo drains one word per rising event unless clock_mirror is set; stalls tx_ready when full
   assign fifo_pop = rise_evt & ~clock_mirror;

   dse_fifo #(
      .WIDTH($bits(dse_tx_word_type)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .in_data(tx_word),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fifo_word),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // fall registers take the word popped at the previous rise
   always_comb begin
      cur_d = cur_q;
      if (fifo_pop && fifo_valid) begin
         cur_d = fifo_word;
      end
      // an empty fifo holds the last bits instead of inventing data
      tx_ce = clock_mirror | fifo_valid | ~rise_evt;
      rise_data = clock_mirror ? 1'b1 : fifo_word.d_rise;
      fall_data = clock_mirror ? 1'b0 : cur_q.d_fall;
      tx_ctl = '{ce: tx_ce, gate: 1'b0, ge: 1'b0, sr: io_sr, reverse_set_reset: io_rev};
      in_ctl = '{ce: in_ce, gate: sync_q[0], ge: 1'b1, sr: io_sr, reverse_set_reset: io_rev};
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cur_q <= '0;
      end else begin
         cur_q <= cur_d;
      end
   end

   // output data pair
   dse_storage_el u_out_reg_rise (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(tx_ctl),
      .clk_evt(rise_evt), .d(rise_data), .q(out_rise)
   );
   dse_storage_el u_out_reg_fall (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(tx_ctl),
      .clk_evt(fall_evt), .d(fall_data), .q(out_fall)
   );
   // output enable pair
   dse_storage_el u_oe_reg_rise (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(tx_ctl),
      .clk_evt(rise_evt), .d(clock_mirror | fifo_word.oe_rise), .q(oe_rise)
   );
   dse_storage_el u_oe_reg_fall (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(tx_ctl),
      .clk_evt(fall_evt), .d(clock_mirror | cur_q.oe_fall), .q(oe_fall)
   );
   // input pair
   dse_storage_el u_in_reg_rise (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(in_ctl),
      .clk_evt(a_rise), .d(in_data), .q(in_rise)
   );
   dse_storage_el u_in_reg_fall (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(in_ctl),
      .clk_evt(b_edge), .d(in_data), .q(in_fall)
   );

   // slice pair: one shared control group, separate data selects
   always_comb begin
      upper_d = upper_sel_bypass ? upper_bypass_in : upper_comb;
      lower_d = lower_sel_bypass ? lower_bypass_in : lower_comb;
   end

   dse_storage_el u_upper_storage_element (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(slice_ctl),
      .clk_evt(1'b1), .d(upper_d), .q(upper_el)
   );
   dse_storage_el u_lower_storage_element (
      .core_clk(core_clk), .rstn(rstn), .cfg(elem_cfg), .ctl(slice_ctl),
      .clk_evt(1'b1), .d(lower_d), .q(lower_el)
   );

   // both captured bits land in core_clk two cycles after the second edge is detected
   always_comb begin
      first_d = captured_bit_first;
      second_d = captured_bit_second;
      rx_valid_d = b_edge_q;
      if (b_edge_q) begin
         first_d = in_rise;
         second_d = in_fall;
      end
      casc_d = in_rise;
      // mux the ddr pairs by phase; one flop stage keeps pads glitch free
      pad_out_d = ddr_mux(ph_q, out_rise, out_fall);
      pad_oe_d = ddr_mux(ph_q, oe_rise, oe_fall);
      fwd_clk_d = (ph_q == PH_HIGH);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         b_edge_q <= 1'b0;
         captured_bit_first <= 1'b0;
         captured_bit_second <= 1'b0;
         rx_valid_q <= 1'b0;
         cascade_out_q <= 1'b0;
         pad_out_q <= 1'b0;
         pad_oe_q <= 1'b0;
         fwd_clk_q <= 1'b0;
         upper_q <= 1'b0;
         lower_q <= 1'b0;
      end else begin
         b_edge_q <= b_edge;
         captured_bit_first <= first_d;
         captured_bit_second <= second_d;
         rx_valid_q <= rx_valid_d;
         cascade_out_q <= casc_d;
         pad_out_q <= pad_out_d;
         pad_oe_q <= pad_oe_d;
         fwd_clk_q <= fwd_clk_d;
         upper_q <= upper_el;
         lower_q <= lower_el;
      end
   end
endmodule // dse_io_top

// >>> dse_io_top_assertions.sv
// Purpose: port-level checks for dse_io_top
// Assumes: slice element clocks on every core edge, polarity masks zero
// Notes: slice outputs trail the element by one core cycle
`timescale 1ns/10ps
module dse_io_top_chk
   import dse_pkg::*;
#(
   parameter int HALF_CYCLES = OUT_HALF_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire dse_cfg_type elem_cfg,
   input wire dse_ctl_type slice_ctl,
   input wire logic upper_comb,
   input wire logic upper_bypass_in,
   input wire logic upper_sel_bypass,
   input wire logic lower_comb,
   input wire logic lower_bypass_in,
   input wire logic lower_sel_bypass,
   input wire logic upper_q,
   input wire logic lower_q,
   input wire logic fwd_clk_q,
   input wire logic rx_valid_q,
   input wire logic captured_bit_first,
   input wire logic captured_bit_second
);
   logic [8:0] hi_cnt_q;
   logic [8:0] hi_cnt_d;
   logic flop_ok;
   logic load_ok;
   logic hold_ok;
   logic upper_src;
   logic lower_src;
   assign flop_ok = !elem_cfg.latch_mode && elem_cfg.pol == 5'h00;
   assign load_ok = flop_ok && slice_ctl.ce && !slice_ctl.sr && !slice_ctl.reverse_set_reset;
   assign hold_ok = flop_ok && !slice_ctl.ce && !slice_ctl.sr && !slice_ctl.reverse_set_reset;
   assign upper_src = upper_sel_bypass ? upper_bypass_in : upper_comb;
   assign lower_src = lower_sel_bypass ? lower_bypass_in : lower_comb;
   // counts high cycles of the forwarded clock
   always_comb begin
      hi_cnt_d = fwd_clk_q ? hi_cnt_q + 9'h001 : 9'h000;
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hi_cnt_q <= 9'h000;
      end else begin
         hi_cnt_q <= hi_cnt_d;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // two quiet cycles needed: an async clear in between would spoil the copy
   upper_load_a: assert property (load_ok ##1 load_ok |-> ##1 upper_q == $past(upper_src, 2))
      else $error("upper slice element did not load its source");
   lower_load_a: assert property (load_ok ##1 load_ok |-> ##1 lower_q == $past(lower_src, 2))
      else $error("lower slice element did not load its source");
   slice_hold_a: assert property (hold_ok ##1 hold_ok |-> ##1 $stable(upper_q) && $stable(lower_q))
      else $error("slice element changed with clock enable low");
   sync_reset_a: assert property (flop_ok && !elem_cfg.sr_async && !elem_cfg.sr_is_set
      && slice_ctl.sr && slice_ctl.reverse_set_reset [*2] |-> ##1 !upper_q && !lower_q)
      else $error("synchronous reset did not beat set");
   sync_set_a: assert property (flop_ok && !elem_cfg.sr_async && elem_cfg.sr_is_set
      && slice_ctl.sr && !slice_ctl.reverse_set_reset [*2] |-> ##1 upper_q && lower_q)
      else $error("synchronous set did not drive high");
   async_clear_a: assert property (elem_cfg.pol == 5'h00 && elem_cfg.sr_async
      && !elem_cfg.sr_is_set && slice_ctl.sr |=> !upper_q && !lower_q)
      else $error("asynchronous clear did not act at once");
   rx_pulse_a: assert property (rx_valid_q |=> !rx_valid_q)
      else $error("receive valid longer than one cycle");
   rx_hold_a: assert property (rx_valid_q |=> ($stable(captured_bit_first)
      && $stable(captured_bit_second)) [*3])
      else $error("captured bits moved right after valid");
   fwd_half_a: assert property ($fell(fwd_clk_q) |-> hi_cnt_q == HALF_CYCLES)
      else $error("forwarded clock high half has wrong length");
endmodule // dse_io_top_chk

bind dse_io_top dse_io_top_chk #(.HALF_CYCLES(HALF_CYCLES)) dse_io_top_chk_inst (
   .core_clk, .rstn, .elem_cfg, .slice_ctl, .upper_comb, .upper_bypass_in,
   .upper_sel_bypass, .lower_comb, .lower_bypass_in, .lower_sel_bypass, .upper_q,
   .lower_q, .fwd_clk_q, .rx_valid_q, .captured_bit_first, .captured_bit_second);

// >>> dse_ddr_src.sv
// Purpose: source-synchronous ddr transmitter feeding the input pair
// Assumes: 200 ns link period, data centred on each clock edge
// Notes: clocks stand still between frames; data shows the inverse after hold
`timescale 1ns/10ps
module dse_ddr_src (
   output logic clk_a,
   output logic clk_b,
   output logic data
);
   initial begin
      clk_a = 1'b0;
      clk_b = 1'b1;
      data = 1'b0;
   end
   task automatic send(input logic b0, input logic b1);
      #7;
      data = b0;
      #50;
      clk_a = 1'b1;
      clk_b = 1'b0;
      #50;
      data = b1;
      #50;
      clk_a = 1'b0;
      clk_b = 1'b1;
      #50;
      data = ~b1;
   endtask
endmodule // dse_ddr_src

// >>> test_dse_io_top.sv
// Purpose: self-checking bench for dse_io_top
// Assumes: default half period of four core cycles
// Notes: io set and reset stay idle, so only slice set and reset are exercised
`timescale 1ns/10ps
module test_dse_io_top
   import dse_pkg::*;
;
   logic core_clk, rstn, single_clock, diff_standard, cascade_en, clock_mirror;
   logic out_enable, tx_valid, tx_ready, pad_out_q, pad_oe_q, fwd_clk_q, pad_in;
   logic input_clock_a, input_clock_b, cascade_in, cascade_out_q, link_data;
   logic captured_bit_first, captured_bit_second, rx_valid_q, upper_q, lower_q;
   logic upper_comb, upper_bypass_in, upper_sel_bypass;
   logic lower_comb, lower_bypass_in, lower_sel_bypass;
   logic in_ce = 1'b1;
   logic io_sr = 1'b0;
   logic io_rev = 1'b0;
   dse_cfg_type elem_cfg;
   dse_ctl_type slice_ctl;
   dse_tx_word_type tx_word;
   int fail_count = 0;
   int comparisons = 0;
   // wrong copy on the unused path catches a bad cascade select
   assign pad_in = (diff_standard && cascade_en) ? ~link_data : link_data;
   assign cascade_in = (diff_standard && cascade_en) ? link_data : ~link_data;
   dse_io_top dse_io_top_inst (.core_clk, .rstn, .elem_cfg, .single_clock,
      .diff_standard, .cascade_en, .clock_mirror, .out_enable, .in_ce, .io_sr, .io_rev,
      .tx_word, .tx_valid, .tx_ready, .pad_out_q, .pad_oe_q, .fwd_clk_q, .pad_in,
      .input_clock_a, .input_clock_b, .cascade_in, .cascade_out_q, .captured_bit_first,
      .captured_bit_second, .rx_valid_q, .slice_ctl, .upper_comb, .upper_bypass_in,
      .upper_sel_bypass, .lower_comb, .lower_bypass_in, .lower_sel_bypass, .upper_q,
      .lower_q);
   dse_ddr_src dse_ddr_src_inst (.clk_a(input_clock_a), .clk_b(input_clock_b),
      .data(link_data));
   task automatic end_sim();
      $display("TB: comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [3:0] e, input logic [3:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wait_fwd(input logic v);
      int n;
      n = 0;
      while (fwd_clk_q !== v && n < 50) begin
         @(negedge core_clk);
         n++;
      end
   endtask
   // sample each half two cycles in, after the pad stage has caught up
   task automatic tx_pair(input logic [3:0] w);
      wait_fwd(1'b0);
      wait_fwd(1'b1);
      repeat (2) @(negedge core_clk);
      chk("tx_rise", {2'h0, w[3], w[1]}, {2'h0, pad_oe_q, pad_out_q});
      wait_fwd(1'b0);
      repeat (2) @(negedge core_clk);
      chk("tx_fall", {2'h0, w[2], w[0]}, {2'h0, pad_oe_q, pad_out_q});
   endtask
   task automatic tx_test();
      for (int i = 0; i < 9; i++) begin
         @(negedge core_clk);
         tx_word = 4'(i * 5 + 3);
         tx_valid = 1'b1;
         chk("tx_ready", {3'h0, 1'(i < 8)}, {3'h0, tx_ready});
      end
      @(negedge core_clk);
      tx_valid = 1'b0;
      out_enable = 1'b1;
      for (int i = 0; i < 8; i++) begin
         tx_pair(4'(i * 5 + 3));
      end
      tx_pair(4'h6);
      out_enable = 1'b0;
   endtask
   task automatic mirror_test();
      @(negedge core_clk);
      clock_mirror = 1'b1;
      out_enable = 1'b1;
      tx_pair(4'hE);
      tx_pair(4'hE);
      out_enable = 1'b0;
      clock_mirror = 1'b0;
   endtask
   task automatic rx_test();
      int n;
      logic b0;
      logic b1;
      for (int i = 0; i < 8; i++) begin
         @(negedge core_clk);
         single_clock = i[0];
         diff_standard = i[1];
         cascade_en = i[1] | i[2];
         b0 = i[2] ^ i[0];
         b1 = ~i[1];
         n = 0;
         fork
            dse_ddr_src_inst.send(b0, b1);
            while (rx_valid_q !== 1'b1 && n < 40) begin
               @(negedge core_clk);
               n++;
            end
         join
         chk("rx_valid", 4'h1, {3'h0, rx_valid_q});
         chk("rx_bits", {2'h0, b0, b1}, {2'h0, captured_bit_first, captured_bit_second});
         chk("cascade_out", {3'h0, b0}, {3'h0, cascade_out_q});
      end
   endtask
   task automatic sl(input logic [7:0] c, input logic [4:0] k, input logic [5:0] d,
         input logic [1:0] e);
      @(negedge core_clk);
      elem_cfg = c;
      slice_ctl = k;
      {upper_comb, upper_bypass_in, upper_sel_bypass} = d[5:3];
      {lower_comb, lower_bypass_in, lower_sel_bypass} = d[2:0];
      repeat (3) @(negedge core_clk);
      chk("slice_q", {2'h0, e}, {2'h0, upper_q, lower_q});
   endtask
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      fail_count++;
      end_sim();
   end
   initial begin
      rstn = 1'b0;
      {single_clock, diff_standard, cascade_en, clock_mirror, out_enable} = 5'h00;
      {elem_cfg, slice_ctl, tx_word, tx_valid} = 18'h00000;
      {upper_comb, upper_bypass_in, upper_sel_bypass} = 3'h0;
      {lower_comb, lower_bypass_in, lower_sel_bypass} = 3'h0;
      repeat (12) @(negedge core_clk);
      chk("reset", 4'h8, {tx_ready, pad_out_q, fwd_clk_q, rx_valid_q});
      rstn = 1'b1;
      tx_test();
      mirror_test();
      rx_test();
      sl(8'h00, 5'h10, 6'h25, 2'h2);
      sl(8'h00, 5'h10, 6'h13, 2'h1);
      sl(8'h00, 5'h00, 6'h24, 2'h1);
      sl(8'h10, 5'h00, 6'h24, 2'h3);
      sl(8'h00, 5'h13, 6'h24, 2'h0);
      sl(8'h00, 5'h11, 6'h00, 2'h3);
      sl(8'h20, 5'h12, 6'h00, 2'h3);
      sl(8'h40, 5'h03, 6'h24, 2'h0);
      sl(8'h40, 5'h01, 6'h00, 2'h3);
      sl(8'h80, 5'h0C, 6'h00, 2'h0);
      sl(8'h80, 5'h0C, 6'h24, 2'h3);
      sl(8'h80, 5'h04, 6'h00, 2'h3);
      sl(8'h80, 5'h02, 6'h24, 2'h0);
      end_sim();
   end
endmodule // test_dse_io_top
